// *** sbst_tap.sv ***
// Test access port of a burst memory: state machine, instruction, scan data.
// Overview of operation
// - 71-bit boundary register for capture instructions
// - Code 000: capture ring, float memory outputs
// - Code 001: load identification word, memory untouched
// - Code 010: capture ring, float memory outputs
// - Code 100: capture ring, no preload, untouched
// - Code 111: one-bit bypass in serial path
// - Identification fields: revision, depth, width, device, vendor
// - Identification bit 0 always one
// - Identification selected at power-up and reset state
// - New instruction acts only at instruction update
// - Data update under sample changes nothing
`timescale 1ns/1ps
`default_nettype none
`include "sbst_regs.svh"
module sbst_tap #(
    parameter int         BSR_W  = `SBST_BSR_W,
    parameter logic [2:0]  ID_REV = 3'h0,   // Arbitrary value.
    parameter logic [4:0]  ID_DEP = 5'h00,  // Arbitrary value.
    parameter logic [5:0]  ID_WID = 6'h21,  // Arbitrary value.
    parameter logic [5:0]  ID_DEV = 6'h15,  // Arbitrary value.
    parameter logic [10:0] ID_VEN = 11'h2A5 // Arbitrary value.
) (
    // Memory clock domain.
    input  wire logic              clk,
    input  wire logic              rst_n,
    // Test link, clocked by the controller.
    input  wire logic              tck,
    input  wire sbst_pkg::sbst_link_t link_in,
    output var  logic              tdo_q,
    output var  logic              tdo_oe_q,
    // Memory side.
    input  wire logic [BSR_W-1:0]  ring_in,
    output var  logic              mem_hiz
);
    import sbst_pkg::*;

    // ****************************************************************
    // Elaboration check.
    // ****************************************************************
    // The serial path needs at least two bits to shift through.
    if (BSR_W < 2) begin : g_bad_width
        $error("boundary register too short");
    end

    // ****************************************************************
    // Declarations.
    // ****************************************************************
    localparam sbst_ident_t IDENT = '{revision: ID_REV, depth: ID_DEP,
                                      width: ID_WID, device: ID_DEV,
                                      vendor: ID_VEN,
                                      present: `SBST_ID_PRESENT};

    sbst_state_t             st_q, st_d;     // Test state machine.
    logic [`SBST_IR_W-1:0]   ir_sh_q, ir_sh_d; // Instruction shifter.
    logic [`SBST_IR_W-1:0]   ir_q, ir_d;     // Active instruction.
    logic [`SBST_ID_W-1:0]   id_q, id_d;     // Identification shifter.
    logic [BSR_W-1:0]        bsr_q, bsr_d;   // Boundary shifter.
    logic                    byp_q, byp_d;   // Bypass bit.
    logic                    hiz_q, hiz_d;   // Float request, test domain.
    logic [BSR_W-1:0]        ring_s;         // Ring after two flops.
    logic                    tdo_d;          // Serial out before the flop.
    logic                    tdo_oe_d;       // Drive enable before the flop.
    logic                    ring_op;        // Instruction captures ring.

    // ****************************************************************
    // Crossings.
    // ****************************************************************
    // Memory pins reach the test domain through two flops on the test
    // clock, so capture never looks at a metastable value.
    sbst_sync #(.W(BSR_W)) u_ring_sync (
        .clk   (tck),
        .rst_n (rst_n),
        .d     (ring_in),
        .q     (ring_s)
    );

    // The float request is a level and crosses by two flops on clk.
    sbst_sync #(.W(1)) u_hiz_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (hiz_q),
        .q     (mem_hiz)
    );

    // ****************************************************************
    // Test state machine.
    // ****************************************************************
    // Next state from the mode select taken at the rising edge.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_RESET:  st_d = link_in.mode_sel ? ST_RESET  : ST_IDLE;
            ST_IDLE:   st_d = link_in.mode_sel ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: st_d = link_in.mode_sel ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: st_d = link_in.mode_sel ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  st_d = link_in.mode_sel ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: st_d = link_in.mode_sel ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  st_d = link_in.mode_sel ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: st_d = link_in.mode_sel ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  st_d = link_in.mode_sel ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: st_d = link_in.mode_sel ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: st_d = link_in.mode_sel ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  st_d = link_in.mode_sel ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: st_d = link_in.mode_sel ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  st_d = link_in.mode_sel ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: st_d = link_in.mode_sel ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  st_d = link_in.mode_sel ? ST_SEL_DR : ST_IDLE;
            default:   st_d = ST_RESET;
        endcase
    end

    // State register; power-up puts the machine in its reset state.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Instruction register.
    // ****************************************************************
    // Shift during instruction shift; take effect at instruction update.
    always_comb begin
        ir_sh_d = ir_sh_q;
        ir_d    = ir_q;
        if (st_q == ST_CAP_IR) begin
            ir_sh_d = `SBST_IR_CAPTURE;
        end else if (st_q == ST_SH_IR) begin
            ir_sh_d = {link_in.data_in, ir_sh_q[`SBST_IR_W-1:1]};
        end
        if (st_q == ST_RESET) begin
            ir_d = `SBST_OP_IDENT;
        end else if (st_q == ST_UP_IR) begin
            ir_d = ir_sh_q;
        end
    end

    // Float request follows the instruction that will be active.
    always_comb begin
        hiz_d = (ir_d == `SBST_OP_RING_Z) ||
                (ir_d == `SBST_OP_SAMPLE_Z);
    end

    // Instruction state; power-up selects identification.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            ir_sh_q <= `SBST_IR_CAPTURE;
            ir_q    <= `SBST_OP_IDENT;
            hiz_q   <= 1'h0;
        end else begin
            ir_sh_q <= ir_sh_d;
            ir_q    <= ir_d;
            hiz_q   <= hiz_d;
        end
    end

    // ****************************************************************
    // Data registers.
    // ****************************************************************
    // The three ring-capturing codes share one boundary register.
    always_comb begin
        ring_op = (ir_q == `SBST_OP_RING_Z) ||
                  (ir_q == `SBST_OP_SAMPLE_Z) ||
                  (ir_q == `SBST_OP_SAMPLE);
    end

    // Capture and shift of the selected data register. Update does
    // nothing at all, since no value is ever preloaded to the pins.
    always_comb begin
        id_d  = id_q;
        bsr_d = bsr_q;
        byp_d = byp_q;
        if (st_q == ST_CAP_DR) begin
            if (ir_q == `SBST_OP_IDENT) begin
                id_d = IDENT;
            end else if (ring_op) begin
                bsr_d = ring_s;
            end else begin
                byp_d = `SBST_BYP_CAPTURE;
            end
        end else if (st_q == ST_SH_DR) begin
            if (ir_q == `SBST_OP_IDENT) begin
                id_d = {link_in.data_in, id_q[`SBST_ID_W-1:1]};
            end else if (ring_op) begin
                bsr_d = {link_in.data_in, bsr_q[BSR_W-1:1]};
            end else begin
                byp_d = link_in.data_in;
            end
        end
    end

    // Data register flops.
    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            id_q  <= '0;
            bsr_q <= '0;
            byp_q <= 1'h0;
        end else begin
            id_q  <= id_d;
            bsr_q <= bsr_d;
            byp_q <= byp_d;
        end
    end

    // ****************************************************************
    // Serial output.
    // ****************************************************************
    // Select the path end; reserved codes fall back to the bypass bit.
    always_comb begin
        tdo_oe_d = (st_q == ST_SH_DR) || (st_q == ST_SH_IR);
        if (st_q == ST_SH_IR) begin
            tdo_d = ir_sh_q[0];
        end else if (ir_q == `SBST_OP_IDENT) begin
            tdo_d = id_q[0];
        end else if (ring_op) begin
            tdo_d = bsr_q[0];
        end else begin
            tdo_d = byp_q;
        end
    end

    // Output changes on the falling edge, half a period before sampling.
    always_ff @(negedge tck or negedge rst_n) begin
        if (!rst_n) begin
            tdo_q    <= 1'h0;
            tdo_oe_q <= 1'h0;
        end else begin
            tdo_q    <= tdo_d;
            tdo_oe_q <= tdo_oe_d;
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_reset_ident: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_RESET) |=> (ir_q == `SBST_OP_IDENT))
        else $error("reset state did not select identification");

    a_ir_update: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_UP_IR) |=> (ir_q == $past(ir_sh_q)))
        else $error("instruction not taken at update");

    a_ir_hold: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q != ST_UP_IR && st_q != ST_RESET) |=> $stable(ir_q))
        else $error("instruction changed outside update");

    a_id_capture: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_CAP_DR && ir_q == `SBST_OP_IDENT)
        |=> (id_q == IDENT) && id_q[0])
        else $error("identification word not captured");

    a_ring_capture: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_CAP_DR && ring_op) |=> (bsr_q == $past(ring_s)))
        else $error("ring not captured into boundary register");

    a_bypass_path: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_SH_DR && ir_q == `SBST_OP_BYPASS)
        ##1 (st_q == ST_SH_DR) |-> (tdo_d == $past(link_in.data_in)))
        else $error("bypass is not a single bit");

    a_float_z: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_UP_IR && (ir_sh_q == `SBST_OP_SAMPLE_Z ||
                              ir_sh_q == `SBST_OP_RING_Z))
        |=> hiz_q ##1 hiz_q)
        else $error("outputs not floated");

    a_sample_live: assert property (
        @(posedge tck) disable iff (!rst_n)
        (ir_q == `SBST_OP_SAMPLE) ##1 (ir_q == `SBST_OP_SAMPLE)
        |-> !hiz_q)
        else $error("sample disturbed memory outputs");

    a_update_quiet: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_UP_DR && ir_q == `SBST_OP_SAMPLE)
        |=> $stable(bsr_q) && $stable(hiz_q))
        else $error("data update changed state under sample");

    a_tdo_gate: assert property (
        @(posedge tck) disable iff (!rst_n)
        tdo_oe_q == ((st_q == ST_SH_DR) || (st_q == ST_SH_IR)))
        else $error("serial out driven outside shift");

    a_ir_capture: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_CAP_IR) |=> (ir_sh_q == `SBST_IR_CAPTURE))
        else $error("instruction capture value wrong");

    a_id_shift: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_SH_DR && ir_q == `SBST_OP_IDENT)
        |=> (id_q == {$past(link_in.data_in), $past(id_q[`SBST_ID_W-1:1])}))
        else $error("identification word not shifted");

    a_byp_capture: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_CAP_DR && ir_q == `SBST_OP_BYPASS)
        |=> (byp_q == `SBST_BYP_CAPTURE))
        else $error("bypass bit did not capture");

    a_ring_shift: assert property (
        @(posedge tck) disable iff (!rst_n)
        (st_q == ST_SH_DR && ring_op)
        |=> (bsr_q == {$past(link_in.data_in), $past(bsr_q[BSR_W-1:1])}))
        else $error("boundary register not shifted");
endmodule
`default_nettype wire

// *** sbst_regs.svh ***
// Constants of the scan port: widths, instruction codes and capture values.
`ifndef SBST_REGS_SVH
`define SBST_REGS_SVH

// ****************************************************************
// Scan register widths.
// ****************************************************************
`define SBST_IR_W       3
`define SBST_ID_W       32
`define SBST_BSR_W      71

// ****************************************************************
// Instruction codes.
// ****************************************************************
`define SBST_OP_RING_Z   3'h0
`define SBST_OP_IDENT    3'h1
`define SBST_OP_SAMPLE_Z 3'h2
`define SBST_OP_SAMPLE   3'h4
`define SBST_OP_BYPASS   3'h7

// ****************************************************************
// Capture and reset values.
// ****************************************************************
`define SBST_IR_CAPTURE  3'h1
`define SBST_ID_PRESENT  1'h1
`define SBST_BYP_CAPTURE 1'h0

`endif

// *** sbst_pkg.sv ***
// Types shared by the scan port design files.
package sbst_pkg;

    // Sixteen states of the test state machine.
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PA_DR, ST_EX2_DR, ST_UP_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UP_IR
    } sbst_state_t;

    // Layout of the identification word, most significant field first.
    typedef struct packed {
        logic [2:0]  revision;
        logic [4:0]  depth;
        logic [5:0]  width;
        logic [5:0]  device;
        logic [10:0] vendor;
        logic        present;
    } sbst_ident_t;

    // Serial inputs from the test controller, taken on the rising edge.
    typedef struct packed {
        logic mode_sel;
        logic data_in;
    } sbst_link_t;

endpackage

// *** sbst_sync.sv ***
// Two-flop synchroniser for a bus of independent levels.
`timescale 1ns/1ps
`default_nettype none
module sbst_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data.
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q; // First stage, read only by the second stage.

    // Both stages clear under reset; only the second stage is read outside.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** sbst_ctl.sv ***
// Model of the external scan controller that drives the test link.
`timescale 1ns/1ps
`default_nettype none
module sbst_ctl (
    // Test link.
    output var  logic                 tck,
    output var  sbst_pkg::sbst_link_t link_in,
    input  wire logic                 tdo_q,
    input  wire logic                 tdo_oe_q
);
    import sbst_pkg::*;

    // The test clock stands still low outside frames.
    initial begin
        tck = 1'h0;
        link_in = '0;
    end

    // One test clock period: the link changes just after the fall and
    // the serial output is taken just before the next rise.
    task automatic step(input logic ms, input logic di, output logic dout,
                        output logic oe);
        link_in.mode_sel = ms;
        link_in.data_in = di;
        // A released serial output reads as the inverse of its last value.
        #14 dout = tdo_oe_q ? tdo_q : ~tdo_q;
        oe = tdo_oe_q;
        #1 tck = 1'h1;
        #15 tck = 1'h0;
    endtask

    // Walks from idle into a shift state and shifts n bits, ending in
    // the first exit state.
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout, output logic oe_ok);
        logic d;
        logic e;
        dout = '0;
        oe_ok = 1'h1;
        // Reserved instruction codes are never loaded.
        if (ir && din[2:0] inside {3'h3, 3'h5, 3'h6}) begin
            din[2:0] = 3'h7;
        end
        step(1'h1, 1'h0, d, e);
        if (ir) begin
            step(1'h1, 1'h0, d, e);
        end
        step(1'h0, 1'h0, d, e);
        step(1'h0, 1'h0, d, e);
        for (int i = 0; i < n; i++) begin
            step(logic'(i == n - 1), din[i], dout[i], e);
            oe_ok &= e;
        end
    endtask

    // Passes through the update state back to idle.
    task automatic finish_scan();
        logic d;
        logic e;
        step(1'h1, 1'h0, d, e);
        step(1'h0, 1'h0, d, e);
    endtask

    // Gives n ones on mode select, then settles in idle.
    task automatic tap_reset(input int n);
        logic d;
        logic e;
        repeat (n) step(1'h1, 1'h0, d, e);
        step(1'h0, 1'h0, d, e);
    endtask
endmodule
`default_nettype wire

// *** sram_boundary_scan_tap_bench.sv ***
// Self-checking bench of the scan port with a model of the controller.
`timescale 1ns/1ps
`default_nettype none
`include "sbst_regs.svh"
module sram_boundary_scan_tap_bench;
    import sbst_pkg::*;

    // Identification fields; the values are arbitrary.
    localparam logic [2:0]  REV    = 3'h5;
    localparam logic [4:0]  DEP    = 5'h0B;
    localparam logic [5:0]  WID    = 6'h2C;
    localparam logic [5:0]  DEV    = 6'h15;
    localparam logic [10:0] VEN    = 11'h2A5;
    localparam logic [31:0] ID_EXP = {REV, DEP, WID, DEV, VEN, 1'h1};

    logic        clk;
    logic        rst_n;
    logic        tck;
    sbst_link_t  link_in;
    logic        tdo_q;
    logic        tdo_oe_q;
    logic [70:0] ring_in;
    logic        mem_hiz;
    logic        cur_hiz;     // Float level the bench expects now.
    int          miscompares; // Mismatches seen.
    int          comparisons; // Comparisons made.

    sbst_tap #(.ID_REV(REV), .ID_DEP(DEP), .ID_WID(WID), .ID_DEV(DEV),
               .ID_VEN(VEN)) u_sbst_tap (
        .clk(clk), .rst_n(rst_n), .tck(tck), .link_in(link_in),
        .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .ring_in(ring_in),
        .mem_hiz(mem_hiz));

    sbst_ctl u_sbst_ctl (.tck(tck), .link_in(link_in), .tdo_q(tdo_q),
                         .tdo_oe_q(tdo_oe_q));

    // Memory clock, 25 ns period.
    initial begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // Compares one value and counts the outcome.
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Waits a bounded time for the float level to reach exp.
    task automatic wait_hiz(input logic exp);
        for (int i = 0; i < 12 && mem_hiz !== exp; i++) @(posedge clk);
        if (mem_hiz !== exp) begin
            check(mem_hiz, exp);
            final_report();
        end
    endtask

    // Loads an instruction; the float level must hold until update.
    task automatic load_ir(input logic [2:0] code);
        logic [127:0] q;
        logic         ok;
        u_sbst_ctl.scan(1'h1, 3, {125'h0, code}, q, ok);
        check(q[2:0], `SBST_IR_CAPTURE);
        check(ok, 1'h1);
        repeat (8) @(posedge clk);
        check(mem_hiz, cur_hiz);
        u_sbst_ctl.finish_scan();
    endtask

    // Power-up selects identification; the word shifts out LSB first.
    task automatic t_reset_ident();
        logic [127:0] q;
        logic         ok;
        check(mem_hiz, 1'h0);
        check(tdo_oe_q, 1'h0);
        u_sbst_ctl.tap_reset(0);
        u_sbst_ctl.scan(1'h0, 32, 128'h0, q, ok);
        check(q[31:0], ID_EXP);
        check(q[0], 1'h1);
        check(ok, 1'h1);
        u_sbst_ctl.finish_scan();
        check(tdo_oe_q, 1'h0);
        check(mem_hiz, 1'h0);
    endtask

    // Capture instructions: ring captured into a 71-bit path.
    task automatic t_ring(input logic [2:0] code, input logic hiz);
        logic [127:0] q;
        logic         ok;
        logic [70:0]  ring;
        ring = {8'hA5 ^ {5'h00, code}, 63'h1234_5678_9ABC_DEF0};
        @(posedge clk);
        ring_in <= ring;
        load_ir(code);
        cur_hiz = hiz;
        wait_hiz(hiz);
        check(mem_hiz, hiz);
        u_sbst_ctl.scan(1'h0, 72, 128'h1, q, ok);
        check(q[71:0], {1'h1, ring});
        u_sbst_ctl.finish_scan();
        repeat (8) @(posedge clk);
        check(mem_hiz, hiz);
    endtask

    // Bypass: one stage that captures zero.
    task automatic t_bypass();
        logic [127:0] q;
        logic         ok;
        load_ir(3'h7);
        cur_hiz = 1'h0;
        wait_hiz(1'h0);
        check(mem_hiz, 1'h0);
        u_sbst_ctl.scan(1'h0, 8, 128'hB6, q, ok);
        check(q[7:0], 8'h6C);
        u_sbst_ctl.finish_scan();
    endtask

    // Test-logic-reset brings identification back and ends floating.
    task automatic t_tap_reset();
        logic [127:0] q;
        logic         ok;
        u_sbst_ctl.tap_reset(5);
        cur_hiz = 1'h0;
        wait_hiz(1'h0);
        check(mem_hiz, 1'h0);
        u_sbst_ctl.scan(1'h0, 32, 128'h0, q, ok);
        check(q[31:0], ID_EXP);
        u_sbst_ctl.finish_scan();
        load_ir(3'h1);
        u_sbst_ctl.scan(1'h0, 32, 128'h0, q, ok);
        check(q[31:0], ID_EXP);
        u_sbst_ctl.finish_scan();
        check(mem_hiz, 1'h0);
    endtask

    // Main sequence.
    initial begin
        rst_n = 1'h0;
        ring_in = '0;
        cur_hiz = 1'h0;
        miscompares = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        t_reset_ident();
        t_ring(3'h0, 1'h1);
        t_ring(3'h2, 1'h1);
        t_ring(3'h4, 1'h0);
        t_bypass();
        t_ring(3'h0, 1'h1);
        t_tap_reset();
        final_report();
    end
endmodule
`default_nettype wire
